// ### hdl/autoneg_partner_status_regs.sv
`timescale 1ns/100ps
`default_nettype none
module autoneg_partner_status_regs #(
	parameter int unsigned ADDR_W = 8
) (
	// clock and reset
	input  wire logic              core_clk,
	input  wire logic              nrst,
	// register bus
	input  wire logic [ADDR_W-1:0] avs_address,
	input  wire logic              avs_read,
	input  wire logic              avs_write,
	input  wire logic [31:0]       avs_writedata,
	input  wire logic [3:0]        avs_byteenable,
	output logic      [31:0]       avs_readdata,
	output logic                   avs_waitrequest,
	output logic      [1:0]        avs_response,
	// negotiation engine side
	input  wire logic              lcw_valid,
	input  wire logic [15:0]       lcw_word,
	input  wire logic              lcw_is_next,
	input  wire logic              partner_ack,
	input  wire logic              parallel_detect_fault,
	input  wire logic              partner_negotiation_capable,
	// status back to the engine
	output logic      [15:0]       partner_ability_reg,
	output logic                   page_received
);
	// the highest register byte address must fit the address port
	if (ADDR_W < 6 || ADDR_W > 16) begin : g_addr_check
		$error("ADDR_W must be between 6 and 16");
	end

	// reset release
	logic              rst_meta;
	logic              rst_n;

	// decoded request
	logic              hit_ability;
	logic              hit_expansion;
	logic              hit_control;
	logic              hit_view;
	logic              hit_any;
	logic              accept;

	// bus registers
	logic [31:0]       control;
	logic [31:0]       next_control;
	logic [31:0]       next_readdata;
	logic              next_waitrequest;
	logic [1:0]        next_response;
	logic              read_clear;

	// block state from the submodules
	logic [15:0]       ability_word;
	logic [15:0]       base_page;
	logic              holds_next;
	logic              base_valid;
	logic [15:0]       negotiation_expansion_reg;

	// engine outputs
	logic [15:0]       next_partner_ability_reg;
	logic              next_page_received;

	lcw_if link ();

	// two-stage release of the asynchronous reset
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			rst_meta <= 1'b0;
			rst_n    <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n    <= rst_meta;
		end
	end

	// engine pages enter the shared carrier
	assign link.page_valid   = lcw_valid;
	assign link.page_word    = lcw_word;
	assign link.page_is_next = lcw_is_next;

	// partner ability capture, base then next pages
	partner_page_capture u_capture (
		.core_clk     (core_clk),
		.rst_n        (rst_n),
		.link         (link),
		.partner_ack  (partner_ack),
		.base_view    (control[an_status_pkg::CTRL_BASE_VIEW]),
		.ability_word (ability_word),
		.base_page    (base_page),
		.holds_next   (holds_next),
		.base_valid   (base_valid)
	);

	// expansion status with clear on read
	expansion_status u_expansion (
		.core_clk                    (core_clk),
		.rst_n                       (rst_n),
		.link                        (link),
		.parallel_detect_fault       (parallel_detect_fault),
		.partner_negotiation_capable (partner_negotiation_capable),
		.partner_next_page_capable   (base_valid & base_page[an_status_pkg::BIT_NEXT_PAGE]),
		.read_clear                  (read_clear),
		.status_word                 (negotiation_expansion_reg)
	);

	// address decode on aligned words, low two address bits ignored
	always_comb begin
		hit_ability   = avs_address[ADDR_W-1:2] == (ADDR_W-2)'(an_status_pkg::IDX_PARTNER_ABILITY);
		hit_expansion = avs_address[ADDR_W-1:2] == (ADDR_W-2)'(an_status_pkg::IDX_EXPANSION);
		hit_control   = avs_address[ADDR_W-1:2] == (ADDR_W-2)'(an_status_pkg::IDX_CONTROL);
		hit_view      = avs_address[ADDR_W-1:2] == (ADDR_W-2)'(an_status_pkg::IDX_VIEW_STATUS);
		hit_any       = hit_ability | hit_expansion | hit_control | hit_view;
	end

	// a request is accepted once, in the cycle that raises the answer
	always_comb begin
		accept     = (avs_read | avs_write) & avs_waitrequest;
		read_clear = accept & avs_read & hit_expansion;
	end

	// answer timing, read data and control writes
	always_comb begin
		next_waitrequest = ~accept;
		next_readdata    = avs_readdata;
		next_response    = avs_response;
		next_control     = control;
		if (accept) begin
			next_response = hit_any ? an_status_pkg::RESP_OKAY : an_status_pkg::RESP_SLAVE_ERROR;
			next_readdata = '0;
			if (avs_read) begin
				if (hit_ability) begin
					next_readdata[15:0] = ability_word;
				end else if (hit_expansion) begin
					next_readdata[15:0] = negotiation_expansion_reg;
				end else if (hit_control) begin
					next_readdata = control;
				end else if (hit_view) begin
					next_readdata[an_status_pkg::VIEW_HOLDS_NEXT] = holds_next;
					next_readdata[an_status_pkg::VIEW_BASE_VALID] = base_valid;
				end
			end else if (hit_control && avs_byteenable[0]) begin
				next_control[an_status_pkg::CTRL_BASE_VIEW] =
					avs_writedata[an_status_pkg::CTRL_BASE_VIEW];
			end
			// writes to the ability and expansion words fall through untouched
		end
	end

	// bus registers
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			avs_waitrequest <= 1'b1;
			avs_readdata    <= '0;
			avs_response    <= an_status_pkg::RESP_OKAY;
			control         <= an_status_pkg::CONTROL_RESET;
		end else begin
			avs_waitrequest <= next_waitrequest;
			avs_readdata    <= next_readdata;
			avs_response    <= next_response;
			control         <= next_control;
		end
	end

	// engine-facing copies of the partner word and page flag
	always_comb begin
		next_partner_ability_reg = ability_word;
		next_page_received       = negotiation_expansion_reg[an_status_pkg::EXP_PAGE_RX];
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			partner_ability_reg <= an_status_pkg::PARTNER_WORD_RESET;
			page_received       <= 1'b0;
		end else begin
			partner_ability_reg <= next_partner_ability_reg;
			page_received       <= next_page_received;
		end
	end
endmodule // autoneg_partner_status_regs
`default_nettype wire

// ### shared/an_status_pkg.sv
package an_status_pkg;
	// register indices, byte address is index times word size
	localparam int unsigned WORD_BYTES           = 4;
	localparam int unsigned IDX_PARTNER_ABILITY  = 8'h05;
	localparam int unsigned IDX_EXPANSION        = 8'h06;
	localparam int unsigned IDX_CONTROL          = 8'h08;
	localparam int unsigned IDX_VIEW_STATUS      = 8'h09;
	// partner ability word fields
	localparam int unsigned BIT_NEXT_PAGE        = 15;
	localparam int unsigned BIT_ACK              = 14;
	localparam int unsigned BIT_REMOTE_FAULT     = 13;
	localparam int unsigned BIT_BASE_RESERVED    = 12;
	localparam int unsigned BIT_MESSAGE_PAGE     = 13;
	localparam int unsigned BIT_COMPLY           = 12;
	localparam int unsigned BIT_TOGGLE           = 11;
	localparam int unsigned BIT_ASYM_PAUSE       = 11;
	localparam int unsigned BIT_SYM_PAUSE        = 10;
	localparam int unsigned TECH_HI              = 9;
	localparam int unsigned TECH_LO              = 5;
	localparam int unsigned SELECTOR_HI          = 4;
	localparam int unsigned CODE_HI              = 10;
	// expansion word fields
	localparam int unsigned EXP_PARALLEL_FAULT   = 4;
	localparam int unsigned EXP_PARTNER_NEXT     = 3;
	localparam int unsigned EXP_LOCAL_NEXT       = 2;
	localparam int unsigned EXP_PAGE_RX          = 1;
	localparam int unsigned EXP_PARTNER_AN       = 0;
	// control and view fields
	localparam int unsigned CTRL_BASE_VIEW       = 0;
	localparam int unsigned VIEW_HOLDS_NEXT      = 0;
	localparam int unsigned VIEW_BASE_VALID      = 1;
	// reset values
	localparam logic [15:0] PARTNER_WORD_RESET   = 16'h0000;
	localparam logic [15:0] EXPANSION_RESET      = 16'h0004;
	localparam logic [31:0] CONTROL_RESET        = 32'h0000_0000;
	// bus answers
	localparam logic [1:0]  RESP_OKAY            = 2'h0;
	localparam logic [1:0]  RESP_SLAVE_ERROR     = 2'h2;
endpackage

// ### shared/lcw_if.sv
`timescale 1ns/100ps
`default_nettype none
// carries received link code words from the engine side to the register logic
interface lcw_if;
	logic        page_valid;
	logic [15:0] page_word;
	logic        page_is_next;
	modport src (output page_valid, output page_word, output page_is_next);
	modport cap (input page_valid, input page_word, input page_is_next);
	modport exp (input page_valid);
endinterface
`default_nettype wire

// ### hdl/partner_page_capture.sv
`timescale 1ns/100ps
`default_nettype none
module partner_page_capture (
	// clock and reset
	input  wire logic        core_clk,
	input  wire logic        rst_n,
	// received pages
	lcw_if.cap               link,
	input  wire logic        partner_ack,
	// view select and results
	input  wire logic        base_view,
	output logic      [15:0] ability_word,
	output logic      [15:0] base_page,
	output logic             holds_next,
	output logic             base_valid
);
	logic [15:0] next_page;
	logic [15:0] next_base_page;
	logic [15:0] next_next_page;
	logic        next_holds_next;
	logic        next_base_valid;
	logic [15:0] next_ability_word;

	// base page replaces the stored base and drops the next page view; next page only after partner asked for next pages
	always_comb begin
		next_base_page  = base_page;
		next_next_page  = next_page;
		next_holds_next = holds_next;
		next_base_valid = base_valid;
		if (link.page_valid && !link.page_is_next) begin
			next_base_page = link.page_word;
			next_base_page[an_status_pkg::BIT_BASE_RESERVED] = 1'b0;
			next_holds_next = 1'b0;
			next_base_valid = 1'b1;
		end else if (link.page_valid && base_valid && base_page[an_status_pkg::BIT_NEXT_PAGE]) begin
			next_next_page  = link.page_word;
			next_holds_next = 1'b1;
		end
		next_ability_word = (next_holds_next && !base_view) ? next_next_page : next_base_page;
		next_ability_word[an_status_pkg::BIT_ACK] = partner_ack;
	end

	// page storage
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			base_page    <= an_status_pkg::PARTNER_WORD_RESET;
			next_page    <= an_status_pkg::PARTNER_WORD_RESET;
			holds_next   <= 1'b0;
			base_valid   <= 1'b0;
			ability_word <= an_status_pkg::PARTNER_WORD_RESET;
		end else begin
			base_page    <= next_base_page;
			next_page    <= next_next_page;
			holds_next   <= next_holds_next;
			base_valid   <= next_base_valid;
			ability_word <= next_ability_word;
		end
	end
endmodule // partner_page_capture
`default_nettype wire

// ### hdl/expansion_status.sv
`timescale 1ns/100ps
`default_nettype none
module expansion_status (
	// clock and reset
	input  wire logic        core_clk,
	input  wire logic        rst_n,
	// events and levels
	lcw_if.exp               link,
	input  wire logic        parallel_detect_fault,
	input  wire logic        partner_negotiation_capable,
	input  wire logic        partner_next_page_capable,
	input  wire logic        read_clear,
	// expansion word
	output logic      [15:0] status_word
);
	logic [15:0] next_status_word;

	// page received is sticky; a new page beats the clear from a read
	always_comb begin
		next_status_word = '0;
		next_status_word[an_status_pkg::EXP_PARALLEL_FAULT] = parallel_detect_fault;
		next_status_word[an_status_pkg::EXP_PARTNER_NEXT] = partner_next_page_capable;
		next_status_word[an_status_pkg::EXP_LOCAL_NEXT] = 1'b1;
		next_status_word[an_status_pkg::EXP_PAGE_RX] = link.page_valid
			| (status_word[an_status_pkg::EXP_PAGE_RX] & ~read_clear);
		next_status_word[an_status_pkg::EXP_PARTNER_AN] = partner_negotiation_capable;
	end

	// status register
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			status_word <= an_status_pkg::EXPANSION_RESET;
		end else begin
			status_word <= next_status_word;
		end
	end
endmodule // expansion_status
`default_nettype wire

// ### bench/autoneg_status_sva.sv
`timescale 1ns/100ps
`default_nettype none
module autoneg_status_sva #(
	parameter int unsigned ADDR_W = 8
) (
	// clock and reset
	input wire logic              core_clk,
	input wire logic              nrst,
	// register bus
	input wire logic [ADDR_W-1:0] avs_address,
	input wire logic              avs_read,
	input wire logic              avs_write,
	input wire logic [31:0]       avs_writedata,
	input wire logic [3:0]        avs_byteenable,
	input wire logic [31:0]       avs_readdata,
	input wire logic              avs_waitrequest,
	input wire logic [1:0]        avs_response,
	// engine side
	input wire logic              lcw_valid,
	input wire logic [15:0]       lcw_word,
	input wire logic              lcw_is_next,
	input wire logic              partner_ack,
	input wire logic              parallel_detect_fault,
	input wire logic              partner_negotiation_capable,
	input wire logic [15:0]       partner_ability_reg,
	input wire logic              page_received
);
	logic [2:0] up, next_up;
	logic       view, next_view;
	logic [5:0] idx;
	logic       ack, map;
	// settle counter and shadow of the base view control
	always_comb begin
		idx = avs_address[7:2];
		ack = (avs_read || avs_write) && !avs_waitrequest;
		map = idx inside {6'h05, 6'h06, 6'h08, 6'h09};
		next_up = (up == 3'h7) ? up : up + 3'h1;
		next_view = view;
		if (ack && avs_write && idx == 6'h08 && avs_byteenable[0])
			next_view = avs_writedata[0];
	end
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			up <= 3'h0;
			view <= 1'b0;
		end else begin
			up <= next_up;
			view <= next_view;
		end
	end
	default clocking @(posedge core_clk); endclocking
	default disable iff (!nrst);
	sequence s_base_next_req;
		lcw_valid && !lcw_is_next && lcw_word[15] && up == 3'h7;
	endsequence
	sequence s_next;
		lcw_valid && lcw_is_next && !view && !avs_write;
	endsequence
	chk_ack_lag: assert property (up == 3'h7 |->
		partner_ability_reg[14] == $past(partner_ack, 2)) else $error("ack bit lag");
	chk_page_set: assert property (lcw_valid && up == 3'h7 |-> ##2 page_received)
		else $error("page flag not set");
	chk_base_copy: assert property (lcw_valid && !lcw_is_next && up == 3'h7 |-> ##2
		(partner_ability_reg & 16'hBFFF) == ($past(lcw_word, 2) & 16'hAFFF))
		else $error("base page copy");
	chk_next_copy: assert property (s_base_next_req ##1 s_next |-> ##2
		(partner_ability_reg & 16'hBFFF) == ($past(lcw_word, 2) & 16'hBFFF))
		else $error("next page copy");
	chk_bus_ack: assert property ((avs_read || avs_write) && avs_waitrequest && up == 3'h7
		|=> !avs_waitrequest ##1 avs_waitrequest) else $error("ack length");
	chk_err_resp: assert property (ack && !map |-> avs_response == 2'h2
		&& (!avs_read || avs_readdata == 32'h0)) else $error("unmapped answer");
	chk_okay_resp: assert property (ack && map |-> avs_response == 2'h0)
		else $error("mapped answer");
	chk_exp_fixed: assert property (ack && avs_read && idx == 6'h06 |->
		avs_readdata[31:5] == 27'h0 && avs_readdata[2]) else $error("expansion fixed bits");
	chk_read_clear: assert property (ack && avs_read && idx == 6'h06 &&
		!$past(lcw_valid) |=> !page_received) else $error("clear on read");
endmodule // autoneg_status_sva
bind autoneg_partner_status_regs autoneg_status_sva #(.ADDR_W(ADDR_W)) u_sva (
	.core_clk(core_clk), .nrst(nrst), .avs_address(avs_address),
	.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
	.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
	.avs_waitrequest(avs_waitrequest), .avs_response(avs_response),
	.lcw_valid(lcw_valid), .lcw_word(lcw_word), .lcw_is_next(lcw_is_next),
	.partner_ack(partner_ack), .parallel_detect_fault(parallel_detect_fault),
	.partner_negotiation_capable(partner_negotiation_capable),
	.partner_ability_reg(partner_ability_reg), .page_received(page_received));
`default_nettype wire

// ### bench/link_partner_model.sv
`timescale 1ns/100ps
`default_nettype none
module link_partner_model (
	input  wire logic        core_clk,
	output var  logic        lcw_valid,
	output var  logic [15:0] lcw_word,
	output var  logic        lcw_is_next,
	output var  logic        partner_ack,
	output var  logic        pd_fault,
	output var  logic        an
);
	// quiet link at time zero
	initial begin
		lcw_valid = 1'b0;
		lcw_word = 16'h0000;
		lcw_is_next = 1'b0;
		partner_ack = 1'b0;
		pd_fault = 1'b0;
		an = 1'b0;
	end
	// one decoded page, word scrambled once released; reserved bit left as sent
	task automatic send(input logic [15:0] w, input logic n);
		@(posedge core_clk);
		lcw_valid <= 1'b1;
		lcw_word <= w;
		lcw_is_next <= n;
		@(posedge core_clk);
		lcw_valid <= 1'b0;
		lcw_word <= ~w;
	endtask
	// base page with next page request, next page straight after it
	task automatic pair(input logic [15:0] b, input logic [15:0] nx);
		@(posedge core_clk);
		lcw_valid <= 1'b1;
		lcw_word <= b;
		lcw_is_next <= 1'b0;
		@(posedge core_clk);
		lcw_word <= nx;
		lcw_is_next <= 1'b1;
		@(posedge core_clk);
		lcw_valid <= 1'b0;
		lcw_word <= ~nx;
	endtask
	// levels decoded from bursts
	task automatic levels(input logic a, input logic f, input logic c);
		@(posedge core_clk);
		partner_ack <= a;
		pd_fault <= f;
		an <= c;
	endtask
endmodule // link_partner_model
`default_nettype wire

// ### bench/autoneg_partner_status_regs_tb.sv
`timescale 1ns/100ps
`default_nettype none
module autoneg_partner_status_regs_tb;
	logic        core_clk, nrst, avs_read, avs_write, lcw_valid, lcw_is_next, pf;
	logic        avs_waitrequest, partner_ack, pd_fault, an, holds, view, prx;
	logic [3:0]  avs_byteenable, be;
	logic [7:0]  avs_address;
	logic [31:0] avs_writedata, avs_readdata, q;
	logic [1:0]  avs_response, r;
	logic [15:0] lcw_word, base, nxt, pa;
	int          err_count = 0, check_count = 0, cyc = 0, seed = 72, i;
	autoneg_partner_status_regs dut (.core_clk(core_clk), .nrst(nrst),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.avs_response(avs_response), .lcw_valid(lcw_valid), .lcw_word(lcw_word),
		.lcw_is_next(lcw_is_next), .partner_ack(partner_ack),
		.parallel_detect_fault(pd_fault), .partner_negotiation_capable(an),
		.partner_ability_reg(pa), .page_received(pf));
	link_partner_model lp (.core_clk(core_clk), .lcw_valid(lcw_valid),
		.lcw_word(lcw_word), .lcw_is_next(lcw_is_next),
		.partner_ack(partner_ack), .pd_fault(pd_fault), .an(an));
	// clock and hang guard
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			err_count = err_count + 1;
			stop_test();
		end
	end
	task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		check_count = check_count + 1;
		if (s !== e) begin
			err_count = err_count + 1;
			$display("[FAIL] %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic stop_test();
		$display("checks %0d errors %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// one bus access, held until waitrequest is seen low
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		avs_address <= a;
		avs_write <= w;
		avs_read <= !w;
		avs_writedata <= d;
		avs_byteenable <= be;
		do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		r = avs_response;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
		bus(1'b0, a, 32'h0);
		chk("rdata", q, e);
		chk("resp", {30'h0, r}, {30'h0, er});
		if (a == 8'h18)
			prx = 1'b0;
	endtask
	// reference model of the visible words
	function automatic logic [31:0] ea();
		return {16'h0, ((holds && !view) ? nxt : base) & 16'hBFFF | {1'b0, partner_ack, 14'h0}};
	endfunction
	function automatic logic [31:0] ee();
		return {27'h0, pd_fault, base[15], 1'b1, prx, an};
	endfunction
	// base page and next page back to back, engine copy checked after
	task automatic pp(input logic [15:0] b, input logic [15:0] nx);
		lp.pair(b, nx);
		base = b & 16'hEFFF;
		nxt = nx;
		holds = b[15];
		prx = 1'b1;
		repeat (2) @(posedge core_clk);
		chk("pcopy", {16'h0, pa}, ea());
	endtask
	task automatic pg(input logic [15:0] w, input logic n);
		lp.send(w, n);
		prx = 1'b1;
		if (!n) begin
			base = w & 16'hEFFF;
			holds = 1'b0;
		end else if (base[15]) begin
			nxt = w;
			holds = 1'b1;
		end
		repeat (2) @(posedge core_clk);
		chk("copy", {16'h0, pa}, ea());
		chk("pflag", {31'h0, pf}, 32'h1);
	endtask
	// main sequence
	initial begin
		{nrst, avs_read, avs_write, holds, view, prx} = 6'h00;
		{avs_address, avs_writedata, base, nxt} = 72'h0;
		{avs_byteenable, be} = 8'hFF;
		repeat (3) @(posedge core_clk);
		nrst <= 1'b1;
		repeat (4) @(posedge core_clk);
		rd(8'h14, 32'h0, 2'h0);
		rd(8'h18, 32'h4, 2'h0);
		for (i = 0; i < 6; i++) begin
			lp.levels(1'($random(seed)), 1'($random(seed)), 1'($random(seed)));
			pg(16'($random(seed)), 1'b0);
			rd(8'h14, ea(), 2'h0);
			rd(8'h18, ee(), 2'h0);
			rd(8'h18, ee(), 2'h0);
		end
		pg(16'($random(seed)) | 16'h8000, 1'b0);
		for (i = 0; i < 4; i++) begin
			pg(16'($random(seed)), 1'b1);
			rd(8'h14, ea(), 2'h0);
		end
		rd(8'h24, {30'h0, 1'b1, holds}, 2'h0);
		pp(16'($random(seed)) | 16'h8000, 16'($random(seed)));
		rd(8'h14, ea(), 2'h0);
		bus(1'b1, 8'h20, 32'h1);
		view = 1'b1;
		rd(8'h20, {31'h0, view}, 2'h0);
		rd(8'h14, ea(), 2'h0);
		bus(1'b1, 8'h20, 32'h0);
		view = 1'b0;
		be = 4'hE;
		bus(1'b1, 8'h20, 32'h1);
		be = 4'hF;
		rd(8'h20, {31'h0, view}, 2'h0);
		pg(16'($random(seed)) & 16'h7FFF, 1'b0);
		pg(16'($random(seed)), 1'b1);
		rd(8'h14, ea(), 2'h0);
		rd(8'h24, {30'h0, 1'b1, holds}, 2'h0);
		rd(8'h18, ee(), 2'h0);
		bus(1'b1, 8'h14, 32'hFFFF_FFFF);
		bus(1'b1, 8'h18, 32'hFFFF_FFFF);
		chk("wresp", {30'h0, r}, 32'h0);
		rd(8'h14, ea(), 2'h0);
		rd(8'h18, ee(), 2'h0);
		rd(8'h40, 32'h0, 2'h2);
		stop_test();
	end
endmodule // autoneg_partner_status_regs_tb
`default_nettype wire
